/* src/modbus_master_consts.svh */
// constants for the rtu master: frame codes, crc, timing, buffer sizes
`ifndef MODBUS_MASTER_CONSTS_SVH
`define MODBUS_MASTER_CONSTS_SVH

// ================================================================
// timing
`define CLK_HZ             64'd40000000
`define BAUD_RATE          64'd9600
`define CHAR_BITS          64'd11
`define GAP_CHARS_X10      64'd35
`define GAP_CYCLES_CALC    ((`CLK_HZ * `CHAR_BITS * `GAP_CHARS_X10 + `BAUD_RATE * 64'd10 - 64'd1) / (`BAUD_RATE * 64'd10))
`define RESP_TIMEOUT_MS    64'd100
`define RESP_TIMEOUT_CALC  (`CLK_HZ * `RESP_TIMEOUT_MS / 64'd1000)

// ================================================================
// frame codes
`define STATION_BCAST      8'h00
`define STATION_MAX        8'hF7
`define FN_READ            8'h03
`define FN_WRITE           8'h06
`define FN_EXC_BIT         8'h80
`define EXC_BAD_FN         8'h01
`define EXC_BAD_ADDR       8'h02
`define EXC_BAD_DATA       8'h03
`define EXC_NOT_DONE       8'h04
`define READ_MAX_WORDS     16'h000C
`define GROUP_SPAN         17'h00100

// ================================================================
// frame lengths and check
`define REQ_BODY_LAST      3'h5
`define REQ_CRC_LO_IDX     3'h6
`define EXC_REPLY_LEN      5'h05
`define WRITE_REPLY_LEN    5'h08
`define READ_REPLY_BASE    5'h05
`define RX_IDX_MAX         5'h1F
`define RX_WORD_BYTES      5'h18
`define CRC_PRESET         16'hFFFF
`define CRC_POLY           16'hA001
`define CRC_RESIDUE        16'h0000

// ================================================================
// receive buffer
`define RX_FIFO_WIDTH      9
`define RX_FIFO_DEPTH      16

`endif

/* src/modbus_master_pkg.sv */
// types shared by the rtu master
package modbus_master_pkg;

    // ================================================================
    // controller sequence
    typedef enum logic [2:0] {
        S_IDLE,
        S_GAP,
        S_SEND,
        S_DRAIN,
        S_RECV,
        S_DELIVER
    } state_t;

    // ================================================================
    // outcome of one request
    typedef enum logic [2:0] {
        RSP_OK,
        RSP_EXCEPTION,
        RSP_FRAME_ERR,
        RSP_TIMEOUT,
        RSP_BAD_REPLY,
        RSP_BAD_REQUEST,
        RSP_BROADCAST
    } status_t;

    // ================================================================
    // whole controller state
    typedef struct packed {
        state_t             st;
        logic [5:0][7:0]    tx_buf;
        logic [2:0]         tx_idx;
        logic [7:0]         tx_byte;
        logic [15:0]        crc;
        logic [31:0]        gap_cnt;
        logic [31:0]        timer;
        logic [4:0]         rx_idx;
        logic [7:0]         rx_station;
        logic [7:0]         rx_fn;
        logic [7:0]         rx_b2;
        logic               echo_bad;
        logic               rx_bad;
        logic [11:0][15:0]  words;
        logic [3:0]         count;
        logic [3:0]         word_idx;
        logic               rd_valid;
        logic [3:0]         rd_index;
        logic [15:0]        rd_data;
        logic               rsp_valid;
        status_t            rsp_status;
        logic [7:0]         rsp_exc;
    } ctrl_t;

endpackage

/* src/crc16_byte.sv */
// one-byte step of the reflected 16-bit frame check
`timescale 1ns/1ps
`default_nettype none
`include "modbus_master_consts.svh"

module crc16_byte (
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data_in,
    output logic      [15:0] crc_out
);
    logic [8:0][15:0] stage;

    // ================================================================
    // byte enters the low half, then eight shift steps
    assign stage[0] = crc_in ^ {8'h00, data_in};

    genvar i;
    for (i = 0; i < 8; i++) begin : g_bit
        assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ `CRC_POLY)
                                         : (stage[i] >> 1);
    end

    assign crc_out = stage[8];
endmodule // crc16_byte

`default_nettype wire

/* src/sync_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic        push;
    logic        pop;

    // ================================================================
    // handshakes and honest full/empty
    assign in_ready  = (s_reg.count != CW'(DEPTH));
    assign out_valid = (s_reg.count != '0);
    assign out_data  = s_reg.mem[s_reg.rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next pointers, storage and fill level
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr_ptr] = in_data;
            s_next.wr_ptr = (s_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_reg.wr_ptr + AW'(1);
        end
        if (pop) begin
            s_next.rd_ptr = (s_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_reg.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + CW'(1);
        end else if (pop && !push) begin
            s_next.count = s_reg.count - CW'(1);
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // sync_fifo

`default_nettype wire

/* src/modbus_rtu_master.sv */
// rtu bus master: builds requests, paces the line, checks and unpacks replies
`timescale 1ns/1ps
`default_nettype none
`include "modbus_master_consts.svh"

module modbus_rtu_master #(
    parameter int unsigned GAP_CYCLES   = 32'(`GAP_CYCLES_CALC),
    parameter int unsigned RESP_TIMEOUT = 32'(`RESP_TIMEOUT_CALC)
) (
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready,
    input  wire logic                       cmd_write,
    input  wire logic [7:0]                 cmd_station,
    input  wire logic [15:0]                cmd_addr,
    input  wire logic [15:0]                cmd_count,
    input  wire logic [15:0]                cmd_data,
    output logic                            tx_valid,
    input  wire logic                       tx_ready,
    output logic      [7:0]                 tx_data,
    input  wire logic                       tx_idle,
    output logic                            driver_en,
    input  wire logic                       rx_valid,
    output logic                            rx_ready,
    input  wire logic [7:0]                 rx_data,
    input  wire logic                       rx_err,
    output logic                            rd_valid,
    output logic      [3:0]                 rd_index,
    output logic      [15:0]                rd_data,
    output logic                            rsp_valid,
    output var modbus_master_pkg::status_t  rsp_status,
    output logic      [7:0]                 rsp_exc_code
);
    modbus_master_pkg::ctrl_t       s_reg;
    modbus_master_pkg::ctrl_t       s_next;
    logic                           fifo_valid;
    logic                           fifo_ready;
    logic [`RX_FIFO_WIDTH-1:0]      fifo_dout;
    logic [7:0]                     rx_byte;
    logic [7:0]                     crc_byte_in;
    logic [15:0]                    crc_out;
    logic                           line_busy;
    logic                           quiet;
    logic                           req_bad;
    logic [4:0]                     rx_k;
    logic [4:0]                     read_len;

    // ================================================================
    // receive buffer between the uart and the parser
    sync_fifo #(
        .WIDTH (`RX_FIFO_WIDTH),
        .DEPTH (`RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_err, rx_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_dout)
    );

    // ================================================================
    // one check step shared by sending and receiving
    assign rx_byte     = fifo_dout[7:0];
    assign crc_byte_in = (s_reg.st == modbus_master_pkg::S_RECV) ? rx_byte : s_reg.tx_byte;

    crc16_byte u_crc (
        .crc_in  (s_reg.crc),
        .data_in (crc_byte_in),
        .crc_out (crc_out)
    );

    // ================================================================
    // line activity and the inter-frame silence
    assign line_busy = (rx_valid & rx_ready) | ~tx_idle | (tx_valid & tx_ready);
    assign quiet     = (s_reg.gap_cnt >= GAP_CYCLES);

    // ================================================================
    // request screening before anything goes on the line
    always_comb begin
        req_bad = 1'b0;
        if (cmd_station > `STATION_MAX) begin
            req_bad = 1'b1;
        end else if (!cmd_write) begin
            if (cmd_station == `STATION_BCAST) begin
                req_bad = 1'b1;
            end else if (cmd_count == 16'h0000 || cmd_count > `READ_MAX_WORDS) begin
                req_bad = 1'b1;
            end else if (17'({9'h000, cmd_addr[7:0]}) + 17'(cmd_count) > `GROUP_SPAN) begin
                req_bad = 1'b1;
            end
        end
    end

    // reply geometry helpers
    assign rx_k     = 5'(s_reg.rx_idx - 5'h03);
    assign read_len = 5'(`READ_REPLY_BASE + {s_reg.count, 1'b0});

    // ================================================================
    // handshakes and driver enable
    assign cmd_ready  = (s_reg.st == modbus_master_pkg::S_IDLE);
    assign tx_valid   = (s_reg.st == modbus_master_pkg::S_SEND);
    assign driver_en  = (s_reg.st == modbus_master_pkg::S_SEND)
                      | (s_reg.st == modbus_master_pkg::S_DRAIN);
    assign fifo_ready = (s_reg.st != modbus_master_pkg::S_DELIVER);

    // outputs straight from the state register
    assign tx_data      = s_reg.tx_byte;
    assign rd_valid     = s_reg.rd_valid;
    assign rd_index     = s_reg.rd_index;
    assign rd_data      = s_reg.rd_data;
    assign rsp_valid    = s_reg.rsp_valid;
    assign rsp_status   = s_reg.rsp_status;
    assign rsp_exc_code = s_reg.rsp_exc;

    // ================================================================
    // next state of the whole controller
    always_comb begin
        s_next = s_reg;
        s_next.rsp_valid = 1'b0;
        s_next.rd_valid  = 1'b0;

        // silence counter, restarted by any traffic
        if (line_busy) begin
            s_next.gap_cnt = '0;
        end else if (!quiet) begin
            s_next.gap_cnt = s_reg.gap_cnt + 32'h0000_0001;
        end

        case (s_reg.st)
            modbus_master_pkg::S_IDLE: begin
                if (cmd_valid) begin
                    if (req_bad) begin
                        s_next.rsp_valid  = 1'b1;
                        s_next.rsp_status = modbus_master_pkg::RSP_BAD_REQUEST;
                        s_next.rsp_exc    = 8'h00;
                    end else begin
                        s_next.tx_buf[0] = cmd_station;
                        s_next.tx_buf[1] = cmd_write ? `FN_WRITE : `FN_READ;
                        s_next.tx_buf[2] = cmd_addr[15:8];
                        s_next.tx_buf[3] = cmd_addr[7:0];
                        s_next.tx_buf[4] = cmd_write ? cmd_data[15:8] : cmd_count[15:8];
                        s_next.tx_buf[5] = cmd_write ? cmd_data[7:0] : cmd_count[7:0];
                        s_next.count     = cmd_count[3:0];
                        s_next.st        = modbus_master_pkg::S_GAP;
                    end
                end
            end

            // wait for a silent line before the first byte
            modbus_master_pkg::S_GAP: begin
                if (quiet) begin
                    s_next.st      = modbus_master_pkg::S_SEND;
                    s_next.tx_idx  = 3'h0;
                    s_next.tx_byte = s_reg.tx_buf[0];
                    s_next.crc     = `CRC_PRESET;
                end
            end

            // six body bytes, then check low and high
            modbus_master_pkg::S_SEND: begin
                if (tx_ready) begin
                    s_next.tx_idx = s_reg.tx_idx + 3'h1;
                    if (s_reg.tx_idx < `REQ_CRC_LO_IDX) begin
                        s_next.crc = crc_out;
                    end
                    if (s_reg.tx_idx < `REQ_BODY_LAST) begin
                        s_next.tx_byte = s_reg.tx_buf[s_reg.tx_idx + 3'h1];
                    end else if (s_reg.tx_idx == `REQ_BODY_LAST) begin
                        s_next.tx_byte = crc_out[7:0];
                    end else if (s_reg.tx_idx == `REQ_CRC_LO_IDX) begin
                        s_next.tx_byte = s_reg.crc[15:8];
                    end else begin
                        s_next.st = modbus_master_pkg::S_DRAIN;
                    end
                end
            end

            // release the line once the uart has shifted out
            modbus_master_pkg::S_DRAIN: begin
                if (tx_idle) begin
                    if (s_reg.tx_buf[0] == `STATION_BCAST) begin
                        s_next.st         = modbus_master_pkg::S_IDLE;
                        s_next.rsp_valid  = 1'b1;
                        s_next.rsp_status = modbus_master_pkg::RSP_BROADCAST;
                        s_next.rsp_exc    = 8'h00;
                    end else begin
                        s_next.st       = modbus_master_pkg::S_RECV;
                        s_next.rx_idx   = 5'h00;
                        s_next.timer    = 32'h0000_0000;
                        s_next.crc      = `CRC_PRESET;
                        s_next.echo_bad = 1'b0;
                        s_next.rx_bad   = 1'b0;
                    end
                end
            end

            // collect the reply until the line goes silent
            modbus_master_pkg::S_RECV: begin
                if (fifo_valid) begin
                    s_next.crc = crc_out;
                    if (fifo_dout[8]) begin
                        s_next.rx_bad = 1'b1;
                    end
                    if (s_reg.rx_idx != `RX_IDX_MAX) begin
                        s_next.rx_idx = s_reg.rx_idx + 5'h01;
                    end
                    if (s_reg.rx_idx == 5'h00) begin
                        s_next.rx_station = rx_byte;
                    end else if (s_reg.rx_idx == 5'h01) begin
                        s_next.rx_fn = rx_byte;
                    end else if (s_reg.rx_idx == 5'h02) begin
                        s_next.rx_b2 = rx_byte;
                    end
                    if (s_reg.rx_idx >= 5'h02 && s_reg.rx_idx <= 5'h05
                        && rx_byte != s_reg.tx_buf[s_reg.rx_idx[2:0]]) begin
                        s_next.echo_bad = 1'b1;
                    end
                    if (s_reg.rx_idx >= 5'h03 && rx_k < `RX_WORD_BYTES) begin
                        if (!rx_k[0]) begin
                            s_next.words[rx_k[4:1]][15:8] = rx_byte;
                        end else begin
                            s_next.words[rx_k[4:1]][7:0] = rx_byte;
                        end
                    end
                end else if (s_reg.rx_idx == 5'h00) begin
                    s_next.timer = s_reg.timer + 32'h0000_0001;
                    if (s_reg.timer >= RESP_TIMEOUT) begin
                        s_next.st         = modbus_master_pkg::S_IDLE;
                        s_next.rsp_valid  = 1'b1;
                        s_next.rsp_status = modbus_master_pkg::RSP_TIMEOUT;
                        s_next.rsp_exc    = 8'h00;
                    end
                end else if (quiet) begin
                    // frame closed by silence: judge it as a whole
                    s_next.st        = modbus_master_pkg::S_IDLE;
                    s_next.rsp_valid = 1'b1;
                    s_next.rsp_exc   = 8'h00;
                    if (s_reg.rx_bad || s_reg.crc != `CRC_RESIDUE
                        || s_reg.rx_idx < `EXC_REPLY_LEN) begin
                        s_next.rsp_status = modbus_master_pkg::RSP_FRAME_ERR;
                    end else if (s_reg.rx_station != s_reg.tx_buf[0]) begin
                        s_next.rsp_status = modbus_master_pkg::RSP_BAD_REPLY;
                    end else if (s_reg.rx_fn == (s_reg.tx_buf[1] | `FN_EXC_BIT)
                                 && s_reg.rx_idx == `EXC_REPLY_LEN) begin
                        s_next.rsp_status = modbus_master_pkg::RSP_EXCEPTION;
                        s_next.rsp_exc    = s_reg.rx_b2;
                    end else if (s_reg.rx_fn != s_reg.tx_buf[1]) begin
                        s_next.rsp_status = modbus_master_pkg::RSP_BAD_REPLY;
                    end else if (s_reg.tx_buf[1] == `FN_WRITE) begin
                        s_next.rsp_status = (s_reg.rx_idx == `WRITE_REPLY_LEN && !s_reg.echo_bad)
                                          ? modbus_master_pkg::RSP_OK
                                          : modbus_master_pkg::RSP_BAD_REPLY;
                    end else if (s_reg.rx_idx == read_len
                                 && s_reg.rx_b2 == {3'b000, s_reg.count, 1'b0}) begin
                        s_next.rsp_valid = 1'b0;
                        s_next.st        = modbus_master_pkg::S_DELIVER;
                        s_next.word_idx  = 4'h0;
                    end else begin
                        s_next.rsp_status = modbus_master_pkg::RSP_BAD_REPLY;
                    end
                end
            end

            // hand the checked words out one per cycle
            modbus_master_pkg::S_DELIVER: begin
                s_next.rd_valid = 1'b1;
                s_next.rd_index = s_reg.word_idx;
                s_next.rd_data  = s_reg.words[s_reg.word_idx];
                if (s_reg.word_idx == 4'(s_reg.count - 4'h1)) begin
                    s_next.st         = modbus_master_pkg::S_IDLE;
                    s_next.rsp_valid  = 1'b1;
                    s_next.rsp_status = modbus_master_pkg::RSP_OK;
                    s_next.rsp_exc    = 8'h00;
                end else begin
                    s_next.word_idx = s_reg.word_idx + 4'h1;
                end
            end

            default: begin
                s_next.st = modbus_master_pkg::S_IDLE;
            end
        endcase
    end

    // ================================================================
    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // modbus_rtu_master

`default_nettype wire

/* verif/modbus_master_props.sv */
// port assertions for the rtu master
`timescale 1ns/1ps
`default_nettype none
module modbus_master_props #(
    parameter int unsigned GAP_CYCLES = 40
) (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic        cmd_write,
    input wire logic [15:0] cmd_count,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        driver_en,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic        rd_valid,
    input wire logic [3:0]  rd_index,
    input wire logic        rsp_valid,
    input var modbus_master_pkg::status_t rsp_status,
    input wire logic [7:0]  rsp_exc_code
);
    // ================================================================
    // silence counter and properties
    logic [31:0] idle_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // cycles since the line was last driven or fed a byte
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) idle_reg <= 32'h0;
        else if (driver_en || (rx_valid && rx_ready)) idle_reg <= 32'h0;
        else idle_reg <= idle_reg + 32'h1;
    end
    sequence s_take; cmd_valid && cmd_ready; endsequence
    sequence s_bad; rsp_valid && rsp_status == modbus_master_pkg::RSP_BAD_REQUEST; endsequence
    a_take_busy: assert property (s_take |=> !cmd_ready || rsp_valid)
        else $error("busy missing");
    a_drive_send: assert property (tx_valid |-> driver_en) else $error("undriven");
    a_gap_first: assert property ($rose(driver_en) |-> idle_reg >= GAP_CYCLES)
        else $error("gap short");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte moved");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("long pulse");
    a_exc_zero: assert property (rsp_valid && rsp_status != modbus_master_pkg::RSP_EXCEPTION
        |-> rsp_exc_code == 8'h00) else $error("stray code");
    a_bad_count: assert property (s_take ##0 (!cmd_write && cmd_count > 16'h000C) |=> s_bad)
        else $error("count kept");
    a_word_order: assert property (rd_valid && !rsp_valid |=> rd_valid
        && rd_index == $past(rd_index) + 4'h1) else $error("word order");
endmodule // modbus_master_props
bind modbus_rtu_master modbus_master_props #(.GAP_CYCLES(GAP_CYCLES)) u_props (.*);
`default_nettype wire

/* verif/modbus_slave_model.sv */
// behavioural slave station with uart stand-in
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       driver_en,
    input  wire logic       rx_ready,
    input  wire logic [1:0] mode,
    output logic            tx_ready,
    output logic            tx_idle,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_err
);
    // ================================================================
    // frame check, byte capture and reply
    logic [7:0]  q[$];
    logic [7:0]  r[$];
    logic [15:0] c;
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] v;
        v = 16'hFFFF;
        foreach (b[i]) begin
            v = v ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) v = v[0] ? (v >> 1) ^ 16'hA001 : v >> 1;
        end
        return v;
    endfunction
    // uart takes a byte every other cycle
    always @(posedge sys_clk) begin
        tx_ready <= !tx_ready && arst_n;
        tx_idle <= !tx_valid;
        if (tx_valid && tx_ready) q.push_back(tx_data);
    end
    // answer once the master lets go of the line
    initial begin
        {tx_ready, tx_idle, rx_valid, rx_data, rx_err} = 12'h400;
        forever begin
            @(posedge sys_clk);
            if (q.size() == 8 && !driver_en) begin
                r = {};
                if (q[0] != 8'h00 && crc(q) == 16'h0000 && mode != 2'h3) begin
                    if (mode == 2'h1) r = {q[0], q[1] | 8'h80, 8'h02};
                    else if (q[1] == 8'h06) r = q[0:5];
                    else r = {q[0], 8'h03, 8'(q[5] * 2)};
                    for (int i = 0; q[1] == 8'h03 && mode == 2'h0 && i < q[5]; i++)
                        r = {r, q[2], 8'(q[3] + i)};
                    c = crc(r);
                    r = {r, c[7:0], c[15:8]};
                end
                q = {};
                foreach (r[i]) begin
                    rx_valid <= 1'b1;
                    rx_data <= r[i];
                    rx_err <= (mode == 2'h2) && (i == 1);
                    do @(posedge sys_clk); while (!rx_ready);
                end
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                rx_err <= 1'b0;
            end
        end
    end
endmodule // modbus_slave_model
`default_nettype wire

/* verif/tb_top.sv */
// testbench for the rtu master against a slave model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ================================================================
    // signals, instances and tasks
    logic sys_clk = 1'b0, arst_n, cmd_valid, cmd_ready, cmd_write, tx_valid, tx_ready, tx_idle;
    logic driver_en, rx_valid, rx_ready, rx_err, rd_valid, rsp_valid;
    logic [7:0] cmd_station, tx_data, rx_data, rsp_exc_code;
    logic [15:0] cmd_addr, cmd_count, cmd_data, rd_data;
    logic [3:0] rd_index;
    logic [1:0] mode;
    modbus_master_pkg::status_t rsp_status;
    int errors = 0, samples_checked = 0, nw;
    modbus_rtu_master #(.GAP_CYCLES(40), .RESP_TIMEOUT(500)) DUT (.*);
    modbus_slave_model u_slave (.*);
    // clock
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic req(input logic w, input logic [7:0] s, input logic [15:0] a, n, d,
        input logic [1:0] m, input modbus_master_pkg::status_t es, input logic [7:0] ex);
        {cmd_valid, cmd_write, cmd_station, cmd_addr, cmd_count, cmd_data} <= {1'b1, w, s, a, n, d};
        mode <= m;
        nw = 0;
        do @(posedge sys_clk); while (!cmd_ready);
        cmd_valid <= 1'b0;
        for (int t = 0; t < 5000 && rsp_valid !== 1'b1; t++) begin
            @(posedge sys_clk);
            if (rd_valid === 1'b1) chk("rd_index", 16'(nw), {12'h000, rd_index});
            if (rd_valid === 1'b1) chk("rd_data", a + 16'(nw), rd_data);
            if (rd_valid === 1'b1) nw++;
        end
        chk("status", 16'(es), 16'(rsp_status));
        chk("exc_code", {8'h00, ex}, {8'h00, rsp_exc_code});
        chk("words", (w || es != modbus_master_pkg::RSP_OK) ? 16'h0 : n, 16'(nw));
        @(posedge sys_clk);
    endtask
    task automatic t_write;
        req(1'b1, 8'h05, 16'h1234, 16'h0000, 16'hABCD, 2'h0, modbus_master_pkg::RSP_OK, 8'h00);
        $display("write test done");
    endtask
    task automatic t_read;
        req(1'b0, 8'hF7, 16'h0310, 16'h000C, 16'h0000, 2'h0, modbus_master_pkg::RSP_OK, 8'h00);
        $display("read test done");
    endtask
    task automatic t_refuse;
        req(1'b0, 8'h03, 16'h0310, 16'h000D, 16'h0, 2'h0, modbus_master_pkg::RSP_BAD_REQUEST, 8'h0);
        req(1'b1, 8'hF8, 16'h0310, 16'h0001, 16'h0, 2'h0, modbus_master_pkg::RSP_BAD_REQUEST, 8'h0);
        $display("refuse test done");
    endtask
    task automatic t_bcast;
        req(1'b1, 8'h00, 16'h2000, 16'h0, 16'h0001, 2'h0, modbus_master_pkg::RSP_BROADCAST, 8'h0);
        $display("broadcast test done");
    endtask
    task automatic t_fault;
        req(1'b0, 8'h03, 16'h0310, 16'h1, 16'h0, 2'h1, modbus_master_pkg::RSP_EXCEPTION, 8'h02);
        req(1'b1, 8'h03, 16'h0310, 16'h0, 16'h5, 2'h2, modbus_master_pkg::RSP_FRAME_ERR, 8'h00);
        req(1'b1, 8'h03, 16'h0310, 16'h0, 16'h5, 2'h3, modbus_master_pkg::RSP_TIMEOUT, 8'h00);
        $display("fault test done");
    endtask
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reset, then the tests in turn
    initial begin
        {arst_n, cmd_valid, cmd_write, cmd_station, cmd_addr, cmd_count, cmd_data, mode} = 0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_write();
        t_read();
        t_refuse();
        t_bcast();
        t_fault();
        test_done();
    end
    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
